/* File: dv/ssc_config_regs_assertions.sv */
// Port checks for the sequencer configuration bank.
`timescale 1ns/1ps
module ssc_config_regs_assertions (
    // Clock, reset and bus.
    input logic        clk_i,
    input logic        rst_i,
    input logic        ce_i,
    input logic        psel_i,
    input logic        penable_i,
    input logic        pwrite_i,
    input logic [11:0] paddr_i,
    input logic [31:0] prdata_o,
    input logic        pready_o,
    input logic        pslverr_o,
    input logic        frame_start_i,
    // Configuration outputs.
    input logic        rolling_shutter_o,
    input logic        readout_delay_en_o,
    input logic [7:0]  readout_delay_o,
    input logic [7:0]  line_duration_extend_o,
    input logic        dual_slope_o,
    input logic        triple_slope_o,
    input logic [7:0]  dark_rows_o,
    input logic [11:0] padding_rows_o,
    input logic [15:0] second_slope_exposure_o,
    input logic [15:0] third_slope_exposure_o,
    input logic [11:0] digital_gain_value_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence apb_setup;
        psel_i && !penable_i && ce_i;
    endsequence
    sequence bad_read;
        apb_setup ##0 (!pwrite_i && paddr_i[11:6] != 6'h0C);
    endsequence
    chk_ready_next: assert property (apb_setup |=> pready_o)
        else $error("pready missing after setup");
    chk_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("pready held too long");
    chk_bad_index: assert property (bad_read |=> pslverr_o && prdata_o == 32'h0)
        else $error("unmapped read not refused");
    chk_dark_floor: assert property (dark_rows_o != 8'h00)
        else $error("dark row count zero");
    chk_pad_ceiling: assert property (padding_rows_o <= 12'h7FF)
        else $error("padding count too large");
    chk_global_lines: assert property (!rolling_shutter_o |-> padding_rows_o == 12'h000 && line_duration_extend_o == 8'h00)
        else $error("rolling field active in global mode");
    chk_slope_mode: assert property (rolling_shutter_o |-> !dual_slope_o && !triple_slope_o && second_slope_exposure_o == 16'h0 && third_slope_exposure_o == 16'h0)
        else $error("slope field active in rolling mode");
    chk_delay_gate: assert property (!readout_delay_en_o |-> readout_delay_o == 8'h00)
        else $error("delay count without enable");
    chk_gain_frame: assert property ($changed(digital_gain_value_o) |-> $past(frame_start_i))
        else $error("gain moved outside frame start");
endmodule // ssc_config_regs_assertions
bind ssc_config_regs ssc_config_regs_assertions u_chk (.*);

/* File: dv/ssc_config_regs_bench.sv */
// Self-checking bench of the sequencer configuration bank.
`timescale 1ns/1ps
`include "ssc_defines.vh"
module ssc_config_regs_bench;
    logic clk_i = 0, rst_i = 1, ce_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic frame_start_i = 0;
    logic [11:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0;
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o, rolling_shutter_o, readout_delay_en_o, subsampling_o;
    wire binning_o, stats_window_o, dual_slope_o, triple_slope_o, period_meaning_sel_o;
    wire gate_first_line_o;
    wire [1:0] analog_gain_first_o;
    wire [2:0] monitor_select_o;
    wire [3:0] analog_gain_second_o;
    wire [7:0] readout_delay_o, line_duration_extend_o, region_select_o, dark_rows_o;
    wire [11:0] padding_rows_o, digital_gain_value_o;
    wire [15:0] exposure_tick_divider_o, frame_or_reset_period_o, exposure_main_o;
    wire [15:0] second_slope_exposure_o, third_slope_exposure_o;
    int errors = 0, tests_run = 0, k;
    logic [31:0] rd;
    logic err;
    logic [15:0] v, w, m;
    logic [79:0] got, exp_v;
    logic [15:0] rst_tab [0:14] = '{16'h0000, 16'h0000, 16'h0004, 16'h0001, 16'h0000,
        16'h0102, 16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h01E2,
        16'h0080, 16'h033F};
    logic [9:0] ridx [0:5] = '{10'h0C0, 10'h0C1, 10'h0C2, 10'h0C3, 10'h0C7, 10'h0C8};
    logic [15:0] rmsk [0:5] = '{16'h3DC2, 16'hFFFF, 16'h0007, 16'h00FF, 16'hFFFF, 16'hFFFF};
    logic [15:0] img [0:5] = '{16'h0000, 16'h0000, 16'h0004, 16'h0001, 16'h0001, 16'h0000};

    ssc_config_regs dut (.*);

    always #50 clk_i = ~clk_i;

    task chk(input logic [79:0] seen, input logic [79:0] expected);
        tests_run++;
        if (seen !== expected) begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, expected);
        end
    endtask

    task apb(input logic wr, input logic [9:0] idx, input logic [15:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= {idx, 2'b00};
        pwdata_i <= {16'h0000, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task fs;
        @(posedge clk_i);
        frame_start_i <= 1'b1;
        @(posedge clk_i);
        frame_start_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    task finish_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_i);
        errors++;
        finish_test;
    end

    initial begin
        void'($urandom(32'hFDB8));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 15; i++) begin
            apb(1'b0, 10'h0C0 + i, 16'h0);
            chk({err, rd}, {17'h0, rst_tab[i]});
        end
        got = {period_meaning_sel_o, gate_first_line_o, dark_rows_o, exposure_tick_divider_o};
        chk(got, {2'b11, 8'h02, 16'h0001});
        apb(1'b0, 10'h0D0, 16'h0);
        chk({err, rd}, {1'b1, 32'h0});
        apb(1'b1, `SSC_IDX_SPARE, 16'hFFFF);
        apb(1'b0, `SSC_IDX_SPARE, 16'h0);
        chk({err, rd}, 33'h0);
        $display("reset and map test done");
        for (int i = 0; i < 24; i++) begin
            k = $urandom_range(5, 0);
            v = $urandom;
            img[k] = v & rmsk[k];
            apb(1'b1, ridx[k], v);
            apb(1'b0, ridx[k], 16'h0);
            chk(rd, img[k]);
        end
        repeat (2) @(posedge clk_i);
        m = img[0];
        got = {rolling_shutter_o, readout_delay_en_o, readout_delay_o, subsampling_o, binning_o};
        chk(got, {m[1], m[6], m[6] ? img[1][15:8] : 8'h00, m[7], m[8]});
        chk(region_select_o, img[3][7:0]);
        got = {stats_window_o, monitor_select_o, dual_slope_o, triple_slope_o, period_meaning_sel_o};
        exp_v = {m[10], m[13:11], img[2][0] & ~m[1], img[2][1] & ~m[1], img[2][2]};
        chk(got, exp_v);
        chk({exposure_tick_divider_o, frame_or_reset_period_o}, {img[4], img[5]});
        $display("random register test done");
        apb(1'b1, `SSC_IDX_MODE, 16'h0002);
        apb(1'b1, `SSC_IDX_PAD, 16'h0FFF);
        apb(1'b1, `SSC_IDX_DARK, 16'h0000);
        v = $urandom;
        apb(1'b1, `SSC_IDX_EXP_MAIN, v);
        repeat (2) @(posedge clk_i);
        got = {padding_rows_o, dark_rows_o, gate_first_line_o, exposure_main_o};
        chk(got, {12'h000, 8'h02, 1'b0, 16'h0000});
        fs;
        got = {padding_rows_o, dark_rows_o, exposure_main_o, line_duration_extend_o};
        chk(got, {12'h7FF, 8'h01, v, img[1][7:0]});
        apb(1'b0, `SSC_IDX_PAD, 16'h0);
        chk(rd, 32'h07FF);
        apb(1'b0, `SSC_IDX_DARK, 16'h0);
        chk(rd, 32'h0001);
        apb(1'b1, `SSC_IDX_SYNC, 16'h0000);
        v = $urandom_range(2047, 0);
        apb(1'b1, `SSC_IDX_PAD, v);
        w = $urandom;
        apb(1'b1, `SSC_IDX_EXP_MAIN, w);
        repeat (2) @(posedge clk_i);
        chk({padding_rows_o, exposure_main_o}, {v[11:0], w});
        apb(1'b1, `SSC_IDX_MODE, 16'h0000);
        apb(1'b1, `SSC_IDX_EXP_SEC, v);
        apb(1'b1, `SSC_IDX_EXP_THIRD, w);
        repeat (2) @(posedge clk_i);
        chk({second_slope_exposure_o, third_slope_exposure_o}, {v, w});
        $display("frame sync test done");
        v = $urandom & 16'h0FFF;
        apb(1'b1, `SSC_IDX_DGAIN, v);
        repeat (2) @(posedge clk_i);
        chk(digital_gain_value_o, 12'h080);
        fs;
        chk(digital_gain_value_o, v[11:0]);
        apb(1'b1, `SSC_IDX_AGAIN, 16'h21E2);
        fs;
        fs;
        w = $urandom & 16'h0FFF;
        apb(1'b1, `SSC_IDX_DGAIN, w);
        fs;
        chk(digital_gain_value_o, v[11:0]);
        ce_i <= 1'b0;
        fs;
        ce_i <= 1'b1;
        chk(digital_gain_value_o, v[11:0]);
        fs;
        got = {analog_gain_first_o, analog_gain_second_o, digital_gain_value_o};
        chk(got, {2'h2, 4'hF, w[11:0]});
        $display("gain test done");
        finish_test;
    end
endmodule // ssc_config_regs_bench

/* File: hdl/ssc_config_regs.v */
// Sequencer configuration register bank with an APB slave and frame-aligned field updates.
//
// How it works
// - Mode bit clear selects global shutter, set selects rolling shutter.
// - Delay enable inserts the programmed wait after row overhead time.
// - Delay count sits in bits 15:8 and matters only while enabled.
// - One bit selects full readout or subsampled readout.
// - One bit selects unbinned readout or pixel binning.
// - Statistics windowing bit picks all windows or the configured window.
// - Three bits choose the signals driven onto the monitor pins.
// - Rolling shutter lines are extended by the eight-bit dummy pixel count.
// - Dual and triple slope enables act in global shutter mode only.
// - Period meaning bit selects reset or frame length, resets to one.
// - Dark row count spans 1 to 255, never below one, resets to 2.
// - First-line gating bit blanks the first output line when set.
// - Padding line count 0 to 2047 inserts dummy lines in rolling mode.
// - Tick divider sets the global shutter time unit, resets to one.
// - Frame or reset period counts in tick units in global shutter mode.
// - Main exposure counts lines when rolling, ticks when global.
// - Second-slope exposure counts ticks, meaningless in rolling shutter.
// - Third-slope exposure counts ticks, meaningless in rolling shutter.
// - Latency compensation postpones gain updates by one more frame.
// - Sync bits make line, dark and padding updates wait for frame start.
// - Exposure sync bit defers exposure updates to frame start.
`timescale 1ns/1ps
`include "ssc_defines.vh"
module ssc_config_regs (
    // Clock, reset and enable.
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        ce_i,
    // APB slave.
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    // Frame timing from the sequencer.
    input  wire        frame_start_i,
    // Mode and readout selection.
    output reg         rolling_shutter_o,
    output reg         readout_delay_en_o,
    output reg  [7:0]  readout_delay_o,
    output reg         subsampling_o,
    output reg         binning_o,
    output reg         stats_window_o,
    output reg  [2:0]  monitor_select_o,
    output reg  [7:0]  line_duration_extend_o,
    output reg  [7:0]  region_select_o,
    // Integration setup.
    output reg         dual_slope_o,
    output reg         triple_slope_o,
    output reg         period_meaning_sel_o,
    // Line counts.
    output reg  [7:0]  dark_rows_o,
    output reg         gate_first_line_o,
    output reg  [11:0] padding_rows_o,
    // Exposure timing.
    output reg  [15:0] exposure_tick_divider_o,
    output reg  [15:0] frame_or_reset_period_o,
    output reg  [15:0] exposure_main_o,
    output reg  [15:0] second_slope_exposure_o,
    output reg  [15:0] third_slope_exposure_o,
    // Gains.
    output reg  [1:0]  analog_gain_first_o,
    output reg  [3:0]  analog_gain_second_o,
    output reg  [11:0] digital_gain_value_o
);
    // Dark row count never goes below one.
    function [7:0] dark_clamp;
        input [7:0] v;
        begin
            dark_clamp = (v < `SSC_DARK_MIN) ? `SSC_DARK_MIN : v;
        end
    endfunction

    // Padding count is limited to its documented range.
    function [11:0] pad_clamp;
        input [11:0] v;
        begin
            pad_clamp = (v > `SSC_PAD_MAX) ? `SSC_PAD_MAX : v;
        end
    endfunction

    wire [9:0]  idx     = paddr_i[11:2];
    wire [15:0] wd      = pwdata_i[15:0];
    wire        setup   = psel_i && !penable_i;
    wire        wr_en   = psel_i && penable_i && pwrite_i && pready_o && ce_i;

    reg  [15:0] mode_reg;
    reg  [15:0] delay_reg;
    reg  [15:0] integ_reg;
    reg  [15:0] region_reg;
    reg  [15:0] dark_reg;
    reg  [15:0] pad_reg;
    reg  [15:0] tick_reg;
    reg  [15:0] period_reg;
    reg  [15:0] exp_main_reg;
    reg  [15:0] exp_sec_reg;
    reg  [15:0] exp_third_reg;
    reg  [15:0] again_reg;
    reg  [15:0] dgain_reg;
    reg  [15:0] sync_reg;

    reg         gain_wr_pend;
    reg         gain_stage_pend;
    reg  [1:0]  stage_ag1;
    reg  [3:0]  stage_ag2;
    reg  [11:0] stage_dg;

    reg  [15:0] rd_word;
    reg         rd_hit;

    wire [7:0]  line_act;
    wire [7:0]  dark_act;
    wire [11:0] pad_act;
    wire [15:0] exp_main_act;
    wire [15:0] exp_sec_act;
    wire [15:0] exp_third_act;
    wire        line_pend;
    wire        dark_pend;
    wire        pad_pend;
    wire        exp_main_pend;
    wire        exp_sec_pend;
    wire        exp_third_pend;

    wire        wr_delay = wr_en && (idx == `SSC_IDX_DELAY);
    wire        wr_dark  = wr_en && (idx == `SSC_IDX_DARK);
    wire        wr_pad   = wr_en && (idx == `SSC_IDX_PAD);
    wire        wr_exp1  = wr_en && (idx == `SSC_IDX_EXP_MAIN);
    wire        wr_exp2  = wr_en && (idx == `SSC_IDX_EXP_SEC);
    wire        wr_exp3  = wr_en && (idx == `SSC_IDX_EXP_THIRD);
    wire        wr_gain  = wr_en && ((idx == `SSC_IDX_AGAIN) || (idx == `SSC_IDX_DGAIN));
    wire        sof      = frame_start_i;
    wire        rolling  = mode_reg[`SSC_BIT_ROLLING];

    // Read decode; the spare word reads as zero and ignores writes.
    always @* begin
        rd_word = 16'h0000;
        rd_hit  = 1'b1;
        case (idx)
            `SSC_IDX_MODE:      rd_word = mode_reg;
            `SSC_IDX_DELAY:     rd_word = delay_reg;
            `SSC_IDX_INTEG:     rd_word = integ_reg;
            `SSC_IDX_REGION:    rd_word = region_reg;
            `SSC_IDX_SPARE:     rd_word = 16'h0000;
            `SSC_IDX_DARK:      rd_word = dark_reg;
            `SSC_IDX_PAD:       rd_word = pad_reg;
            `SSC_IDX_TICK:      rd_word = tick_reg;
            `SSC_IDX_PERIOD:    rd_word = period_reg;
            `SSC_IDX_EXP_MAIN:  rd_word = exp_main_reg;
            `SSC_IDX_EXP_SEC:   rd_word = exp_sec_reg;
            `SSC_IDX_EXP_THIRD: rd_word = exp_third_reg;
            `SSC_IDX_AGAIN:     rd_word = again_reg;
            `SSC_IDX_DGAIN:     rd_word = dgain_reg;
            `SSC_IDX_SYNC:      rd_word = sync_reg;
            `SSC_IDX_STATUS:    rd_word = {8'h00, gain_stage_pend, gain_wr_pend,
                                           exp_third_pend, exp_sec_pend, exp_main_pend,
                                           pad_pend, dark_pend, line_pend};
            default:            rd_hit  = 1'b0;
        endcase
    end

    // APB slave: answer in the first access cycle, write at the completing edge.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else if (ce_i) begin
            if (setup) begin
                pready_o  <= 1'b1;
                pslverr_o <= !rd_hit || (pwrite_i && (idx == `SSC_IDX_STATUS));
                prdata_o  <= pwrite_i ? 32'h0000_0000 : {16'h0000, rd_word};
            end else begin
                pready_o  <= 1'b0;
                pslverr_o <= 1'b0;
            end
        end
    end

    // Register words as software wrote them.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_reg      <= `SSC_RST_MODE;
            delay_reg     <= `SSC_RST_DELAY;
            integ_reg     <= `SSC_RST_INTEG;
            region_reg    <= `SSC_RST_REGION;
            dark_reg      <= `SSC_RST_DARK;
            pad_reg       <= `SSC_RST_PAD;
            tick_reg      <= `SSC_RST_TICK;
            period_reg    <= `SSC_RST_ZERO;
            exp_main_reg  <= `SSC_RST_ZERO;
            exp_sec_reg   <= `SSC_RST_ZERO;
            exp_third_reg <= `SSC_RST_ZERO;
            again_reg     <= `SSC_RST_AGAIN;
            dgain_reg     <= `SSC_RST_DGAIN;
            sync_reg      <= `SSC_RST_SYNC;
        end else if (wr_en) begin
            case (idx)
                `SSC_IDX_MODE:      mode_reg      <= wd & `SSC_MASK_MODE;
                `SSC_IDX_DELAY:     delay_reg     <= wd;
                `SSC_IDX_INTEG:     integ_reg     <= wd & `SSC_MASK_INTEG;
                `SSC_IDX_REGION:    region_reg    <= wd & `SSC_MASK_REGION;
                `SSC_IDX_DARK:      dark_reg      <= {7'h00, wd[`SSC_BIT_GATE],
                                                      dark_clamp(wd[`SSC_DARK_HI:`SSC_DARK_LO])};
                `SSC_IDX_PAD:       pad_reg       <= {4'h0, pad_clamp(wd[`SSC_PAD_HI:`SSC_PAD_LO])};
                `SSC_IDX_TICK:      tick_reg      <= wd;
                `SSC_IDX_PERIOD:    period_reg    <= wd;
                `SSC_IDX_EXP_MAIN:  exp_main_reg  <= wd;
                `SSC_IDX_EXP_SEC:   exp_sec_reg   <= wd;
                `SSC_IDX_EXP_THIRD: exp_third_reg <= wd;
                `SSC_IDX_AGAIN:     again_reg     <= wd & `SSC_MASK_AGAIN;
                `SSC_IDX_DGAIN:     dgain_reg     <= wd & `SSC_MASK_DGAIN;
                `SSC_IDX_SYNC:      sync_reg      <= wd;
                default:            mode_reg      <= mode_reg;
            endcase
        end
    end

    // Frame-aligned fields.
    ssc_shadow #(.W(8), .RST(8'h00)) u_line (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .load_i    (wr_delay),
        .value_i   (wd[`SSC_EXT_HI:`SSC_EXT_LO]),
        .sync_i    (sync_reg[`SSC_BIT_SYNC_LINE]),
        .sof_i     (sof),
        .active_o  (line_act),
        .pending_o (line_pend)
    );

    ssc_shadow #(.W(8), .RST(`SSC_RST_DROWS)) u_dark (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .load_i    (wr_dark),
        .value_i   (dark_clamp(wd[`SSC_DARK_HI:`SSC_DARK_LO])),
        .sync_i    (sync_reg[`SSC_BIT_SYNC_DARK]),
        .sof_i     (sof),
        .active_o  (dark_act),
        .pending_o (dark_pend)
    );

    ssc_shadow #(.W(12), .RST(12'h000)) u_pad (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .load_i    (wr_pad),
        .value_i   (pad_clamp(wd[`SSC_PAD_HI:`SSC_PAD_LO])),
        .sync_i    (sync_reg[`SSC_BIT_SYNC_PAD]),
        .sof_i     (sof),
        .active_o  (pad_act),
        .pending_o (pad_pend)
    );

    ssc_shadow #(.W(16), .RST(16'h0000)) u_exp1 (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .load_i    (wr_exp1),
        .value_i   (wd),
        .sync_i    (sync_reg[`SSC_BIT_SYNC_EXP]),
        .sof_i     (sof),
        .active_o  (exp_main_act),
        .pending_o (exp_main_pend)
    );

    ssc_shadow #(.W(16), .RST(16'h0000)) u_exp2 (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .load_i    (wr_exp2),
        .value_i   (wd),
        .sync_i    (sync_reg[`SSC_BIT_SYNC_EXP]),
        .sof_i     (sof),
        .active_o  (exp_sec_act),
        .pending_o (exp_sec_pend)
    );

    ssc_shadow #(.W(16), .RST(16'h0000)) u_exp3 (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .load_i    (wr_exp3),
        .value_i   (wd),
        .sync_i    (sync_reg[`SSC_BIT_SYNC_EXP]),
        .sof_i     (sof),
        .active_o  (exp_third_act),
        .pending_o (exp_third_pend)
    );

    // Gains move at frame start, through an extra frame stage when compensating latency.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gain_wr_pend         <= 1'b0;
            gain_stage_pend      <= 1'b0;
            stage_ag1            <= `SSC_RST_AG1;
            stage_ag2            <= `SSC_RST_AG2;
            stage_dg             <= `SSC_RST_DG;
            analog_gain_first_o  <= `SSC_RST_AG1;
            analog_gain_second_o <= `SSC_RST_AG2;
            digital_gain_value_o <= `SSC_RST_DG;
        end else if (ce_i) begin
            if (sof) begin
                gain_stage_pend <= 1'b0;
                if (gain_stage_pend) begin
                    analog_gain_first_o  <= stage_ag1;
                    analog_gain_second_o <= stage_ag2;
                    digital_gain_value_o <= stage_dg;
                end
                if (gain_wr_pend && again_reg[`SSC_BIT_LATCOMP]) begin
                    stage_ag1       <= again_reg[`SSC_AG1_HI:`SSC_AG1_LO];
                    stage_ag2       <= again_reg[`SSC_AG2_HI:`SSC_AG2_LO];
                    stage_dg        <= dgain_reg[`SSC_DG_HI:`SSC_DG_LO];
                    gain_stage_pend <= 1'b1;
                end else if (gain_wr_pend) begin
                    analog_gain_first_o  <= again_reg[`SSC_AG1_HI:`SSC_AG1_LO];
                    analog_gain_second_o <= again_reg[`SSC_AG2_HI:`SSC_AG2_LO];
                    digital_gain_value_o <= dgain_reg[`SSC_DG_HI:`SSC_DG_LO];
                end
            end
            if (wr_gain) begin
                gain_wr_pend <= 1'b1;
            end else if (sof) begin
                gain_wr_pend <= 1'b0;
            end
        end
    end

    // Effective settings seen by the sequencer, qualified by the shutter mode.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rolling_shutter_o       <= 1'b0;
            readout_delay_en_o      <= 1'b0;
            readout_delay_o         <= 8'h00;
            subsampling_o           <= 1'b0;
            binning_o               <= 1'b0;
            stats_window_o          <= 1'b0;
            monitor_select_o        <= 3'h0;
            line_duration_extend_o  <= 8'h00;
            region_select_o         <= `SSC_RST_RSEL;
            dual_slope_o            <= 1'b0;
            triple_slope_o          <= 1'b0;
            period_meaning_sel_o    <= 1'b1;
            dark_rows_o             <= `SSC_RST_DROWS;
            gate_first_line_o       <= 1'b1;
            padding_rows_o          <= 12'h000;
            exposure_tick_divider_o <= `SSC_RST_TICK;
            frame_or_reset_period_o <= 16'h0000;
            exposure_main_o         <= 16'h0000;
            second_slope_exposure_o <= 16'h0000;
            third_slope_exposure_o  <= 16'h0000;
        end else if (ce_i) begin
            rolling_shutter_o       <= rolling;
            readout_delay_en_o      <= mode_reg[`SSC_BIT_DLY_EN];
            readout_delay_o         <= mode_reg[`SSC_BIT_DLY_EN] ?
                                       delay_reg[`SSC_DLY_HI:`SSC_DLY_LO] : 8'h00;
            subsampling_o           <= mode_reg[`SSC_BIT_SUBSAMP];
            binning_o               <= mode_reg[`SSC_BIT_BINNING];
            stats_window_o          <= mode_reg[`SSC_BIT_STATWIN];
            monitor_select_o        <= mode_reg[`SSC_MON_HI:`SSC_MON_LO];
            line_duration_extend_o  <= rolling ? line_act : 8'h00;
            region_select_o         <= region_reg[7:0];
            dual_slope_o            <= !rolling && integ_reg[`SSC_BIT_DUAL];
            triple_slope_o          <= !rolling && integ_reg[`SSC_BIT_TRIPLE];
            period_meaning_sel_o    <= integ_reg[`SSC_BIT_PERMEAN];
            dark_rows_o             <= dark_act;
            gate_first_line_o       <= dark_reg[`SSC_BIT_GATE];
            padding_rows_o          <= rolling ? pad_act : 12'h000;
            exposure_tick_divider_o <= tick_reg;
            frame_or_reset_period_o <= period_reg;
            exposure_main_o         <= exp_main_act;
            second_slope_exposure_o <= rolling ? 16'h0000 : exp_sec_act;
            third_slope_exposure_o  <= rolling ? 16'h0000 : exp_third_act;
        end
    end
endmodule // ssc_config_regs

/* File: hdl/ssc_defines.vh */
// Register indices, field positions, reset values and limits of the sequencer configuration bank.
`ifndef SSC_DEFINES_VH
`define SSC_DEFINES_VH

`define SSC_IDX_MODE       10'h0C0
`define SSC_IDX_DELAY      10'h0C1
`define SSC_IDX_INTEG      10'h0C2
`define SSC_IDX_REGION     10'h0C3
`define SSC_IDX_SPARE      10'h0C4
`define SSC_IDX_DARK       10'h0C5
`define SSC_IDX_PAD        10'h0C6
`define SSC_IDX_TICK       10'h0C7
`define SSC_IDX_PERIOD     10'h0C8
`define SSC_IDX_EXP_MAIN   10'h0C9
`define SSC_IDX_EXP_SEC    10'h0CA
`define SSC_IDX_EXP_THIRD  10'h0CB
`define SSC_IDX_AGAIN      10'h0CC
`define SSC_IDX_DGAIN      10'h0CD
`define SSC_IDX_SYNC       10'h0CE
`define SSC_IDX_STATUS     10'h0CF

`define SSC_RST_MODE       16'h0000
`define SSC_RST_DELAY      16'h0000
`define SSC_RST_INTEG      16'h0004
`define SSC_RST_REGION     16'h0001
`define SSC_RST_DARK       16'h0102
`define SSC_RST_PAD        16'h0000
`define SSC_RST_TICK       16'h0001
`define SSC_RST_ZERO       16'h0000
`define SSC_RST_AGAIN      16'h01E2
`define SSC_RST_DGAIN      16'h0080
`define SSC_RST_SYNC       16'h033F
`define SSC_RST_AG1        2'h2
`define SSC_RST_AG2        4'hF
`define SSC_RST_DG         12'h080
`define SSC_RST_DROWS      8'h02
`define SSC_RST_RSEL       8'h01

`define SSC_MASK_MODE      16'h3DC2
`define SSC_MASK_INTEG     16'h0007
`define SSC_MASK_REGION    16'h00FF
`define SSC_MASK_DARK      16'h01FF
`define SSC_MASK_PAD       16'h0FFF
`define SSC_MASK_AGAIN     16'h21E3
`define SSC_MASK_DGAIN     16'h0FFF

`define SSC_BIT_ROLLING    1
`define SSC_BIT_DLY_EN     6
`define SSC_BIT_SUBSAMP    7
`define SSC_BIT_BINNING    8
`define SSC_BIT_STATWIN    10
`define SSC_MON_HI         13
`define SSC_MON_LO         11
`define SSC_EXT_HI         7
`define SSC_EXT_LO         0
`define SSC_DLY_HI         15
`define SSC_DLY_LO         8
`define SSC_BIT_DUAL       0
`define SSC_BIT_TRIPLE     1
`define SSC_BIT_PERMEAN    2
`define SSC_DARK_HI        7
`define SSC_DARK_LO        0
`define SSC_BIT_GATE       8
`define SSC_PAD_HI         11
`define SSC_PAD_LO         0
`define SSC_AG1_HI         1
`define SSC_AG1_LO         0
`define SSC_AG2_HI         8
`define SSC_AG2_LO         5
`define SSC_BIT_LATCOMP    13
`define SSC_DG_HI          11
`define SSC_DG_LO          0
`define SSC_BIT_SYNC_LINE  0
`define SSC_BIT_SYNC_DARK  1
`define SSC_BIT_SYNC_PAD   2
`define SSC_BIT_SYNC_EXP   3

`define SSC_DARK_MIN       8'h01
`define SSC_PAD_MAX        12'h7FF

`endif

/* File: hdl/ssc_shadow.v */
// Shadow and active copy of one field, transferred at frame start when aligned updates are on.
`timescale 1ns/1ps
module ssc_shadow #(
    parameter         W   = 16,
    parameter [W-1:0] RST = {W{1'b0}}
) (
    // Clock, reset and enable.
    input  wire         clk_i,
    input  wire         rst_i,
    input  wire         ce_i,
    // Update request.
    input  wire         load_i,
    input  wire [W-1:0] value_i,
    input  wire         sync_i,
    input  wire         sof_i,
    // Active copy and pending flag.
    output reg  [W-1:0] active_o,
    output reg          pending_o
);
    reg [W-1:0] shadow;

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shadow    <= RST;
            active_o  <= RST;
            pending_o <= 1'b0;
        end else if (ce_i) begin
            if (load_i) begin
                shadow <= value_i;
            end
            if (sof_i && pending_o) begin
                active_o <= shadow;
            end
            if (load_i && !sync_i) begin
                active_o  <= value_i;
                pending_o <= 1'b0;
            end else if (load_i) begin
                pending_o <= 1'b1;
            end else if (sof_i) begin
                pending_o <= 1'b0;
            end
        end
    end
endmodule // ssc_shadow
